// File: atp_conv.v
`timescale 1ns/100ps
`include "atp_defines.vh"
// per-conversion pulse generator: convert low pulse then scan pulse
module atp_conv (
  // clock and reset
  input  wire clock_i,
  input  wire rst_n_i,
  input  wire ce_i,
  // control
  input  wire start_i,    // one-cycle conversion request
  input  wire scan_en_i,  // scan pulse enable
  // outputs
  output reg  conv_n_o,   // active-low conversion marker
  output reg  scan_o,     // scan pulse
  output wire busy_o      // conversion in progress
);
  localparam ST_IDLE   = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_PULSE  = 2'b10;
  reg [1:0] state;  // sequencer state
  reg [7:0] cnt;    // phase counter
  assign busy_o = (state != ST_IDLE);
  // sequencer
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= ST_IDLE;
      cnt      <= 8'h00;
      conv_n_o <= 1'b1;
      scan_o   <= 1'b0;
    end else if (ce_i) begin
      case (state)
        ST_IDLE: begin
          if (start_i) begin
            conv_n_o <= 1'b0;
            cnt      <= `ATP_SAMPLE_CYC;
            state    <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (cnt == 8'h01) begin
            conv_n_o <= 1'b1;
            scan_o   <= scan_en_i;
            cnt      <= `ATP_PULSE_CYC;
            state    <= ST_PULSE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        ST_PULSE: begin
          if (cnt == 8'h01) begin
            scan_o <= 1'b0;
            state  <= ST_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // atp_conv

// File: atp_defines.vh
// Overview of operation
// - lines six/seven steer counter 0/1 direction
// - one scan pulse per conversion when enabled
// - scan pulse rises after sample taken
// - software toggles active-low external strobe level
// - posttrigger: start marker rises at sequence start
// - pretrigger: start marker rises at pretrigger start
// - pretrigger: post marker rises at posttrigger start
// - posttrigger-only: post marker stays idle
// - conversion output falls on every conversion
// - input zero selectable: timing input or analog trigger
// - each channel pair differential or two single-ended
// - direction taps never disturb line operation
// - all digital lines high impedance after reset
`ifndef ATP_DEFINES_VH
`define ATP_DEFINES_VH
// register word addresses
`define ATP_ADDR_CTRL    4'h0
`define ATP_ADDR_ACQ     4'h1
`define ATP_ADDR_DIO_OUT 4'h2
`define ATP_ADDR_DIO_DIR 4'h3
`define ATP_ADDR_PAIR    4'h4
`define ATP_ADDR_STATUS  4'h5
// control register fields
`define ATP_CTRL_STROBE   0
`define ATP_CTRL_SCAN_EN  1
`define ATP_CTRL_PRETRIG  2
`define ATP_CTRL_OE_START 3
`define ATP_CTRL_OE_POST  4
`define ATP_CTRL_OE_CONV  5
`define ATP_CTRL_ATRIG    6
// acquisition register fields (write one to act)
`define ATP_ACQ_ARM  0
`define ATP_ACQ_TRIG 1
`define ATP_ACQ_STOP 2
// reset values
`define ATP_CTRL_RST 8'h01
// timing: sample hold width and scan pulse width in cycles
`define ATP_SAMPLE_CYC 8'h02
`define ATP_PULSE_CYC  8'h02
`endif

// File: atp_ext.sv
`timescale 1ns/100ps
// test circuitry on the connector side of the digital lines
module atp_ext #(
  parameter NDIO = 8
) (
  // device side of each line
  input  wire [NDIO-1:0] dev_val_i,  // device drive value
  input  wire [NDIO-1:0] dev_oe_i,   // device drives when high
  // test circuitry side
  input  wire [NDIO-1:0] ext_val_i,  // circuitry drive value
  input  wire            ext_oe_i,   // circuitry drives when high
  // resolved pin level
  output wire [NDIO-1:0] pin_o
);
  // undriven lines float up through the pull-ups
  wire [NDIO-1:0] far = ext_oe_i ? ext_val_i : {NDIO{1'b1}};
  assign pin_o = (dev_oe_i & dev_val_i) | (~dev_oe_i & far);
endmodule // atp_ext

// File: atp_sync.v
`timescale 1ns/100ps
// two-flop synchroniser, one per bit
module atp_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire             ce_i,
  // data
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;  // first stage, read by second only
  reg [WIDTH-1:0] sync;  // second stage
  // two stage capture
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= {WIDTH{1'b0}};
      sync <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      meta <= d_i;
      sync <= meta;
    end
  end
  assign q_o = sync;
endmodule // atp_sync

// File: atp_top.v
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "atp_defines.vh"
// connector timing logic with avalon-mm register slave
module atp_top #(
  parameter NPAIR = 8,   // channel pairs
  parameter NDIO  = 8    // general digital lines
) (
  // clock, reset, enable
  input  wire            clock_i,
  input  wire            rst_n_i,
  input  wire            ce_i,
  // avalon-mm slave
  input  wire [3:0]      avs_address_i,
  input  wire            avs_read_i,
  input  wire            avs_write_i,
  input  wire [31:0]     avs_writedata_i,
  input  wire [3:0]      avs_byteenable_i,
  output reg  [31:0]     avs_readdata_o,
  output wire            avs_waitrequest_o,
  // conversion request from the sample clock
  input  wire            conv_req_i,
  // general digital lines
  input  wire [NDIO-1:0] gp_line_i,
  output reg  [NDIO-1:0] gp_line_o,
  output reg  [NDIO-1:0] gp_line_oe_o,
  // counter direction controls
  output wire            ctr0_up_o,
  output wire            ctr1_up_o,
  // programmable pin zero: input or start marker output
  input  wire            prog_input_zero_i,
  output wire            acq_start_marker_o,
  output wire            acq_start_marker_oe_o,
  // programmable pin one: post marker output
  output wire            post_phase_marker_o,
  output wire            post_phase_marker_oe_o,
  // programmable pin two: conversion output
  output wire            conv_n_o,
  output wire            conv_n_oe_o,
  // scan pulse and strobe
  output wire            scan_pulse_out_o,
  output wire            sw_strobe_n_o,
  // routed trigger sources
  output wire            timing_input_o,
  output wire            analog_trig_src_o,
  // channel pair modes, 1 = differential
  output wire [NPAIR-1:0] pair_diff_o,
  // acquisition active
  output wire            acq_active_o
);
  // acquisition phases
  localparam PH_IDLE = 2'b00;
  localparam PH_PRE  = 2'b01;
  localparam PH_POST = 2'b10;

  reg  [7:0]       ctrl;        // control register
  reg  [NPAIR-1:0] pair_diff;   // pair mode register
  reg  [1:0]       phase;       // acquisition phase
  reg              start_mark;  // start marker level
  reg              post_mark;   // post marker level
  reg              rd_ack;      // read answer cycle
  wire [NDIO-1:0]  line_s;      // synchronised lines
  wire             pin0_s;      // synchronised pin zero
  wire             busy;        // conversion busy
  wire             conv_n;      // conversion marker
  wire             wr_en;       // accepted write
  wire             acq_cmd;     // command write
  wire [31:0]      status;      // status word

  // line synchronisers
  atp_sync #(.WIDTH(NDIO + 1)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .d_i     ({prog_input_zero_i, gp_line_i}),
    .q_o     ({pin0_s, line_s})
  );

  // conversion and scan pulse sequencer
  atp_conv u_conv (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .start_i   (conv_req_i && (phase != PH_IDLE) && !busy),
    .scan_en_i (ctrl[`ATP_CTRL_SCAN_EN]),
    .conv_n_o  (conv_n),
    .scan_o    (scan_pulse_out_o),
    .busy_o    (busy)
  );

  // writes take one cycle; reads wait one cycle for data
  assign avs_waitrequest_o = avs_read_i && !rd_ack;
  assign wr_en   = avs_write_i && ce_i;
  assign acq_cmd = wr_en && (avs_address_i == `ATP_ADDR_ACQ)
                   && avs_byteenable_i[0];

  // register writes
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl         <= `ATP_CTRL_RST;
      gp_line_o    <= {NDIO{1'b0}};
      gp_line_oe_o <= {NDIO{1'b0}};
      pair_diff    <= {NPAIR{1'b0}};
    end else if (wr_en && avs_byteenable_i[0]) begin
      case (avs_address_i)
        `ATP_ADDR_CTRL: begin
          ctrl <= avs_writedata_i[7:0];
        end
        `ATP_ADDR_DIO_OUT: begin
          gp_line_o <= avs_writedata_i[NDIO-1:0];
        end
        `ATP_ADDR_DIO_DIR: begin
          gp_line_oe_o <= avs_writedata_i[NDIO-1:0];
        end
        `ATP_ADDR_PAIR: begin
          pair_diff <= avs_writedata_i[NPAIR-1:0];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // acquisition phase and markers
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase      <= PH_IDLE;
      start_mark <= 1'b0;
      post_mark  <= 1'b0;
    end else if (ce_i) begin
      if (acq_cmd && avs_writedata_i[`ATP_ACQ_STOP]) begin
        phase      <= PH_IDLE;
        start_mark <= 1'b0;
        post_mark  <= 1'b0;
      end else if (acq_cmd && avs_writedata_i[`ATP_ACQ_ARM]
                   && phase == PH_IDLE) begin
        start_mark <= 1'b1;
        post_mark  <= 1'b0;
        phase <= ctrl[`ATP_CTRL_PRETRIG] ? PH_PRE : PH_POST;
      end else if (acq_cmd && avs_writedata_i[`ATP_ACQ_TRIG]
                   && phase == PH_PRE) begin
        post_mark <= 1'b1;
        phase     <= PH_POST;
      end
    end
  end

  // read answer
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ack         <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_ack <= avs_read_i && !rd_ack;
      if (avs_read_i && !rd_ack) begin
        case (avs_address_i)
          `ATP_ADDR_CTRL:    avs_readdata_o <= {24'h000000, ctrl};
          `ATP_ADDR_DIO_OUT: avs_readdata_o <= {24'h000000, line_s};
          `ATP_ADDR_DIO_DIR: avs_readdata_o <= {24'h000000, gp_line_oe_o};
          `ATP_ADDR_PAIR:    avs_readdata_o <= {24'h000000, pair_diff};
          `ATP_ADDR_STATUS:  avs_readdata_o <= status;
          default:           avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // status: phase, markers, busy, pin zero
  assign status = {26'h0, pin0_s, busy, post_mark, start_mark,
                   phase};

  assign ctr0_up_o = line_s[6];
  assign ctr1_up_o = line_s[7];

  assign analog_trig_src_o = ctrl[`ATP_CTRL_ATRIG] ? pin0_s : 1'b0;
  assign timing_input_o    = ctrl[`ATP_CTRL_ATRIG] ? 1'b0 : pin0_s;

  assign acq_start_marker_oe_o  = ctrl[`ATP_CTRL_OE_START];
  assign post_phase_marker_oe_o = ctrl[`ATP_CTRL_OE_POST];
  assign conv_n_oe_o            = ctrl[`ATP_CTRL_OE_CONV];
  assign acq_start_marker_o     = start_mark;
  assign post_phase_marker_o    = post_mark;
  assign conv_n_o               = conv_n;
  assign sw_strobe_n_o          = ctrl[`ATP_CTRL_STROBE];
  assign pair_diff_o            = pair_diff;
  assign acq_active_o           = (phase != PH_IDLE);
endmodule // atp_top

// File: atp_top_monitor.sv
`timescale 1ns/100ps
// port-level checker for the connector timing block
module atp_top_monitor #(
  parameter NPAIR = 8,
  parameter NDIO  = 8
) (
  // clock and reset
  input wire             clock_i,
  input wire             rst_n_i,
  // register bus
  input wire [3:0]       avs_address_i,
  input wire             avs_write_i,
  input wire [31:0]      avs_writedata_i,
  input wire [3:0]       avs_byteenable_i,
  input wire             avs_waitrequest_o,
  // pins
  input wire             conv_req_i,
  input wire [NDIO-1:0]  gp_line_i,
  input wire [NDIO-1:0]  gp_line_oe_o,
  input wire             ctr0_up_o,
  input wire             ctr1_up_o,
  input wire             acq_start_marker_oe_o,
  input wire             conv_n_o,
  input wire             scan_pulse_out_o,
  input wire             sw_strobe_n_o,
  input wire [NPAIR-1:0] pair_diff_o
);
  // accepted write on byte lane 0
  wire wr0 = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_conv_low_two: assert property ($fell(conv_n_o) |->
    $past(conv_req_i) ##1 !conv_n_o ##1 conv_n_o)
    else $error("conversion low pulse wrong");
  a_scan_after_hold: assert property ($rose(scan_pulse_out_o)
    |-> $rose(conv_n_o)) else $error("scan rose before sample end");
  a_scan_width_two: assert property ($rose(scan_pulse_out_o)
    |=> scan_pulse_out_o ##1 !scan_pulse_out_o)
    else $error("scan pulse width wrong");
  a_reset_lines_off: assert property (disable iff (1'b0)
    !rst_n_i |-> gp_line_oe_o == {NDIO{1'b0}})
    else $error("line driven in reset");
  a_dir_follows_line: assert property ($past(rst_n_i, 2)
    && $past(rst_n_i) |-> ctr0_up_o == $past(gp_line_i[6], 2)
    && ctr1_up_o == $past(gp_line_i[7], 2))
    else $error("counter direction not from lines");
  a_strobe_sw_level: assert property (wr0 && avs_address_i == 4'h0
    |=> sw_strobe_n_o == $past(avs_writedata_i[0]))
    else $error("strobe level not as written");
  a_pin_enable_sw: assert property (wr0 && avs_address_i == 4'h0
    |=> acq_start_marker_oe_o == $past(avs_writedata_i[3]))
    else $error("pin driver enable not as written");
  a_pair_mode_set: assert property (wr0 && avs_address_i == 4'h4
    |=> pair_diff_o == $past(avs_writedata_i[NPAIR-1:0]))
    else $error("pair mode not as written");

  c_conv: cover property ($fell(conv_n_o));
  c_scan: cover property ($rose(scan_pulse_out_o));
  c_pair: cover property (wr0 && avs_address_i == 4'h4);
endmodule // atp_top_monitor

bind atp_top atp_top_monitor #(.NPAIR(NPAIR), .NDIO(NDIO)) u_mon (.*);

// File: atp_top_test.sv
`timescale 1ns/100ps
`include "atp_defines.vh"
module atp_top_test;
  // bench drive
  logic        clock_i  = 1'b0;
  logic        rst_n_i;
  logic [3:0]  av_addr  = 4'h0;
  logic        av_rd    = 1'b0;
  logic        av_wr    = 1'b0;
  logic [31:0] av_wd    = 32'h0;
  logic [3:0]  av_be    = 4'hF;
  logic        conv_req = 1'b0;
  logic        pin0     = 1'b0;
  logic [7:0]  ext_val  = 8'h00;
  logic        ext_oe   = 1'b0;
  logic [31:0] rdat;
  // design outputs
  wire [31:0]  rdata;
  wire [7:0]   pins, lo, loe, pd;
  wire         wreq, c0, c1, sm, smoe, pm, pmoe, cvn, cvoe, sc, stb, ti, at;
  wire         act;
  int fail_count = 0, cmp_count = 0, cyc = 0, nconv = 0, nscan = 0;

  always #50 clock_i = ~clock_i;

  atp_top u_atp_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_writedata_i(av_wd), .avs_byteenable_i(av_be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .conv_req_i(conv_req), .gp_line_i(pins), .gp_line_o(lo),
    .gp_line_oe_o(loe), .ctr0_up_o(c0), .ctr1_up_o(c1),
    .prog_input_zero_i(pin0), .acq_start_marker_o(sm),
    .acq_start_marker_oe_o(smoe), .post_phase_marker_o(pm),
    .post_phase_marker_oe_o(pmoe), .conv_n_o(cvn), .conv_n_oe_o(cvoe),
    .scan_pulse_out_o(sc), .sw_strobe_n_o(stb), .timing_input_o(ti),
    .analog_trig_src_o(at), .pair_diff_o(pd), .acq_active_o(act));

  atp_ext u_atp_ext (.dev_val_i(lo), .dev_oe_i(loe), .ext_val_i(ext_val),
    .ext_oe_i(ext_oe), .pin_o(pins));

  // count conversion markers and scan pulses
  always @(negedge cvn) nconv++;
  always @(posedge sc) nscan++;

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one bus cycle, held until waitrequest is seen low
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] be = 4'hF);
    logic ws;
    av_addr <= a;
    av_wd <= d;
    av_be <= be;
    av_wr <= w;
    av_rd <= !w;
    // waitrequest and read data both taken at the rising edge
    do begin
      @(posedge clock_i);
      ws = wreq;
      rdat = rdata;
    end while (ws);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clock_i);
  endtask

  // one-cycle conversion request, then a gap
  task conv(input int gap);
    conv_req <= 1'b1;
    @(posedge clock_i);
    conv_req <= 1'b0;
    repeat (gap) @(posedge clock_i);
  endtask

  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      test_done;
    end
  end

  initial begin
    // falling from unknown gives the design a reset edge at time zero
    rst_n_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    chk(loe, 8'h00);
    chk({pmoe, smoe, cvoe}, 3'b000);
    chk(stb, 1'b1);
    acc(0, `ATP_ADDR_CTRL, 32'h0);
    chk(rdat, 32'h1);
    acc(0, 4'hF, 32'h0);
    chk(rdat, 32'h0);
    $display("test reset done");
    acc(1, `ATP_ADDR_DIO_DIR, 32'hFF);
    acc(1, `ATP_ADDR_DIO_OUT, 32'hA5);
    repeat (3) @(posedge clock_i);
    chk({loe, lo}, 16'hFFA5);
    chk({c1, c0}, 2'b10);
    ext_oe <= 1'b1;
    ext_val <= 8'h40;
    acc(1, `ATP_ADDR_DIO_DIR, 32'h00);
    repeat (3) @(posedge clock_i);
    chk({c1, c0}, 2'b01);
    acc(0, `ATP_ADDR_DIO_OUT, 32'h0);
    chk(rdat, 32'h40);
    acc(1, `ATP_ADDR_PAIR, 32'h5A);
    chk(pd, 8'h5A);
    acc(1, `ATP_ADDR_PAIR, 32'hFF, 4'h0);
    chk(pd, 8'h5A);
    $display("test lines done");
    acc(1, `ATP_ADDR_CTRL, 32'h0);
    chk(stb, 1'b0);
    pin0 <= 1'b1;
    acc(1, `ATP_ADDR_CTRL, 32'h41);
    repeat (3) @(posedge clock_i);
    chk({at, ti, stb}, 3'b101);
    acc(1, `ATP_ADDR_CTRL, 32'h01);
    repeat (3) @(posedge clock_i);
    chk({at, ti, stb}, 3'b011);
    $display("test routing done");
    acc(1, `ATP_ADDR_CTRL, 32'h3B);
    chk({pmoe, smoe, cvoe}, 3'b111);
    acc(1, `ATP_ADDR_ACQ, 32'h1);
    repeat (2) @(posedge clock_i);
    chk({pm, sm}, 2'b01);
    chk(act, 1'b1);
    acc(0, `ATP_ADDR_STATUS, 32'h0);
    chk(rdat, 32'h26);
    nconv = 0;
    nscan = 0;
    conv(4);
    conv(1);
    conv(6);
    conv(6);
    chk(nconv, 3);
    chk(nscan, 3);
    acc(1, `ATP_ADDR_ACQ, 32'h2);
    chk(pm, 1'b0);
    acc(1, `ATP_ADDR_ACQ, 32'h4);
    chk(act, 1'b0);
    conv(6);
    chk(nconv, 3);
    $display("test posttrigger done");
    acc(1, `ATP_ADDR_CTRL, 32'h3F);
    acc(1, `ATP_ADDR_ACQ, 32'h1);
    repeat (2) @(posedge clock_i);
    chk({pm, sm}, 2'b01);
    acc(0, `ATP_ADDR_STATUS, 32'h0);
    chk(rdat, 32'h25);
    acc(1, `ATP_ADDR_ACQ, 32'h2);
    repeat (2) @(posedge clock_i);
    chk({pm, sm}, 2'b11);
    acc(1, `ATP_ADDR_CTRL, 32'h3D);
    conv(6);
    chk({nconv[7:0], nscan[7:0]}, 16'h0403);
    acc(1, `ATP_ADDR_ACQ, 32'h4);
    chk({pm, sm}, 2'b00);
    $display("test pretrigger done");
    test_done;
  end
endmodule // atp_top_test
